/* core/dsfr_host.sv */
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module dsfr_host
  import dsfr_pkg::*;
#(
  parameter int CAL_WAIT_CYCLES = CAL_WAIT_CYC,
  parameter int HALF_CYC = SCLK_HALF_CYC
)(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  dsfr_link_if.host LINK,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SHIFT = 3'b001,
    H_END = 3'b010,
    H_RPULSE = 3'b011,
    H_WAIT = 3'b100
  } dsfr_hstate_type;

  dsfr_hstate_type state;
  logic [7:0] div;
  logic [31:0] shreg;
  logic [5:0] bits;
  logic [15:0] wait_cnt;
  logic [15:0] post_wait;
  logic [1:0] dev_addr;
  logic chk_en;
  logic cal_done;
  logic refused;
  logic sclk;
  logic cs_b;
  logic rst_drv_b;

  ////////////////////////////////////////////////////////////////
  // decode
  // rate below limit
  wire tick = (div == 8'(HALF_CYC - 1));
  wire idle = (state == H_IDLE);
  wire [4:0] w_reg = WDATA[20:16];
  wire [15:0] w_data = WDATA[15:0];
  wire [23:0] upper = {1'b0, dev_addr, w_reg, w_data};
  wire early_en = (w_reg == REG_OUT_CONFIG) & (w_data[OC_VOLT_EN] | w_data[OC_CURR_EN]) & ~cal_done;
  wire wr_frame = WR & (ADDR == HOST_FRAME);
  wire go_frame = wr_frame & idle & ~early_en;
  wire go_reset = WR & (ADDR == HOST_CTRL) & WDATA[0] & idle;
  wire rd_status = RD & (ADDR == HOST_STATUS);
  wire is_cal = (w_reg == REG_KEY) & (w_data == KEY_CAL_REFRESH);
  wire is_srst = (w_reg == REG_KEY) & (w_data == KEY_SOFT_RESET);
  wire [15:0] next_wait = is_cal ? 16'(CAL_WAIT_CYCLES) : (is_srst ? 16'(QUIET_CYC) : 16'h0001);

  ////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state <= H_IDLE;
      div <= 8'h00;
      shreg <= 32'h00000000;
      bits <= 6'h00;
      wait_cnt <= 16'h0000;
      post_wait <= 16'h0000;
      sclk <= 1'b1;
      cs_b <= 1'b1;
      rst_drv_b <= 1'b1;
    end
    else
    begin
      div <= (tick || idle) ? 8'h00 : div + 8'h01;
      case (state)
        H_IDLE:
        begin
          if (go_frame)
          begin
            shreg <= {upper, chk_en ? dsfr_crc8(upper) : 8'h00};
            bits <= 6'h00;
            post_wait <= next_wait;
            cs_b <= 1'b0;
            state <= H_SHIFT;
          end
          else if (go_reset)
          begin
            rst_drv_b <= 1'b0;
            wait_cnt <= 16'(RESET_PULSE_CYC);
            state <= H_RPULSE;
          end
        end
        H_SHIFT:
        begin
          if (tick && sclk)
          begin
            sclk <= 1'b0;
            bits <= bits + 6'h01;
          end
          else if (tick)
          begin
            sclk <= 1'b1;
            if (bits == 6'(FRAME_BITS))
            begin
              state <= H_END;
            end
            else
            begin
              shreg <= {shreg[30:0], 1'b0};
            end
          end
        end
        H_END:
        begin
          if (tick)
          begin
            cs_b <= 1'b1;
            wait_cnt <= post_wait;
            state <= H_WAIT;
          end
        end
        H_RPULSE:
        begin
          wait_cnt <= wait_cnt - 16'h0001;
          if (wait_cnt == 16'h0001)
          begin
            rst_drv_b <= 1'b1;
            wait_cnt <= 16'(QUIET_CYC);
            state <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          wait_cnt <= wait_cnt - 16'h0001;
          if (wait_cnt <= 16'h0001)
          begin
            state <= H_IDLE;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // controller registers
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dev_addr <= 2'b00;
      chk_en <= 1'b1;
      cal_done <= 1'b0;
      refused <= 1'b0;
      RDATA <= 32'h00000000;
    end
    else
    begin
      RDATA <= rd_status ? {28'h0000000, ~idle, chk_en, cal_done, refused} : 32'h00000000;
      if (wr_frame)
      begin
        refused <= ~go_frame;
      end
      if (WR && ADDR == HOST_CTRL)
      begin
        dev_addr <= WDATA[2:1];
      end
      if (go_reset || (go_frame && is_srst))
      begin
        chk_en <= 1'b1;
        cal_done <= 1'b0;
      end
      else if (go_frame && is_cal)
      begin
        cal_done <= 1'b1;
      end
      else if (go_frame && w_reg == REG_GEN_SETUP_ONE)
      begin
        chk_en <= w_data[GS_CHECK_EN];
      end
    end
  end

  assign LINK.sclk = sclk;
  assign LINK.cs_b = cs_b;
  assign LINK.sdi = shreg[31];
  assign LINK.reset_b = rst_drv_b;
endmodule : dsfr_host

/* core/dsfr_pkg.sv */
// What this block does
// - checked frames are 32-bit words
// - most significant bit sent and assembled first
// - device samples data on serial clock fall
// - unchecked mode uses 24-bit word
// - unchecked mode drops last eight bits
// - fixed slip, address, register, data, check fields
// - data codes are straight binary only
// - host serial clock at most 50 MHz
// - never both current and voltage enabled
// - software picks voltage span and overrange
// - software picks current range and resistor
// - both outputs disabled after any reset
// - pull-down switch open after reset, settable
// - host refreshes calibration before enabling output
// - host waits 500 us after refresh
// - held in reset until supplies good
// - reset pin and software command reset fully
// - host silent 100 us after reset
package dsfr_pkg;
  localparam int FRAME_BITS = 32;
  localparam int SHORT_BITS = 24;
  localparam int CHECK_BITS = 8;
  localparam int SLIP_POS = 31;
  localparam int DEVA_MSB = 30;
  localparam int DEVA_LSB = 29;
  localparam int REGA_MSB = 28;
  localparam int REGA_LSB = 24;
  localparam int DATA_MSB = 23;
  localparam int DATA_LSB = 8;
  localparam int SYNC_STAGES = 2;
  // device register addresses
  localparam logic [4:0] REG_DAC_INPUT = 5'h01;
  localparam logic [4:0] REG_OUT_CONFIG = 5'h02;
  localparam logic [4:0] REG_GEN_SETUP_ONE = 5'h03;
  localparam logic [4:0] REG_CONV_SETUP_TWO = 5'h04;
  localparam logic [4:0] REG_KEY = 5'h08;
  localparam logic [15:0] KEY_SOFT_RESET = 16'hA5C3;
  localparam logic [15:0] KEY_CAL_REFRESH = 16'hFCBA;
  // register fields and reset values
  localparam int OC_VOLT_EN = 0;
  localparam int OC_CURR_EN = 1;
  localparam int OC_VRANGE_LSB = 2;
  localparam int OC_OVERRANGE = 4;
  localparam int OC_CRANGE_LSB = 5;
  localparam int OC_EXT_RES = 8;
  localparam int GS_CHECK_EN = 0;
  localparam int CS_PULLDOWN = 0;
  localparam logic [15:0] DAC_RST = 16'h0000;
  localparam logic [15:0] OUT_CONFIG_RST = 16'h0000;
  localparam logic [15:0] GEN_SETUP_RST = 16'h0001;
  localparam logic [15:0] CONV_SETUP_RST = 16'h0000;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int SCLK_MAX_MHZ = 50;
  localparam int SCLK_HALF_CYC = 4;
  localparam int CAL_WAIT_US = 500;
  localparam int CAL_WAIT_CYC = CAL_WAIT_US * CLK_MHZ;
  localparam int QUIET_US = 100;
  localparam int QUIET_CYC = QUIET_US * CLK_MHZ;
  localparam int RESET_PULSE_CYC = 8;
  // host controller registers
  localparam logic [3:0] HOST_FRAME = 4'h0;
  localparam logic [3:0] HOST_CTRL = 4'h4;
  localparam logic [3:0] HOST_STATUS = 4'h8;
  localparam logic [7:0] CRC_POLY = 8'h07;

  ////////////////////////////////////////////////////////////////
  // check byte over the upper 24 bits, msb first, zero seed
  function automatic logic [7:0] dsfr_crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : dsfr_crc8
endpackage : dsfr_pkg

/* core/dsfr_link_if.sv */
`timescale 1ns/100ps
interface dsfr_link_if;
  logic sclk;
  logic cs_b;
  logic sdi;
  logic reset_b;
  modport host (output sclk, output cs_b, output sdi, output reset_b);
  modport device (input sclk, input cs_b, input sdi, input reset_b);
endinterface : dsfr_link_if

/* core/dsfr_sync.sv */
`timescale 1ns/100ps
module dsfr_sync
  import dsfr_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : dsfr_sync

/* core/dsfr_device.sv */
`timescale 1ns/100ps
module dsfr_device
  import dsfr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  dsfr_link_if.device LINK,
  input wire logic POWER_GOOD,
  input wire logic [1:0] DEV_ADDR,
  output logic [15:0] DAC_CODE,
  output logic VOLT_EN,
  output logic CURR_EN,
  output logic [1:0] VOLT_RANGE,
  output logic OVERRANGE_EN,
  output logic [2:0] CURR_RANGE,
  output logic EXT_RESISTOR,
  output logic PULLDOWN_CLOSED,
  output logic CHECK_EN,
  output logic CAL_REFRESHED,
  output logic IN_RESET,
  output logic FRAME_ERR
);
  // idle levels: sclk high, cs_b high, sdi low, reset_b high, power good
  localparam logic [6:0] SYNC_INIT = 7'h6C;

  logic [6:0] synced;
  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic rpin_s;
  logic pg_s;
  logic [1:0] addr_s;
  logic sclk_q;
  logic cs_q;
  logic [31:0] shreg;
  logic [23:0] short_word;
  logic [5:0] cnt;
  logic [15:0] out_cfg;
  logic [15:0] gen_setup;
  logic [15:0] conv_setup;
  logic soft_rst;

  ////////////////////////////////////////////////////////////////
  // pin crossing
  dsfr_sync #(.WIDTH(7), .INIT(SYNC_INIT)) u_sync (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .d({LINK.sclk, LINK.cs_b, LINK.sdi, LINK.reset_b, POWER_GOOD, DEV_ADDR}),
    .q(synced)
  );
  assign {sclk_s, cs_s, sdi_s, rpin_s, pg_s, addr_s} = synced;

  ////////////////////////////////////////////////////////////////
  // decode
  wire sclk_fall = sclk_q & ~sclk_s;
  wire frame_end = cs_s & ~cs_q;
  wire chk = gen_setup[GS_CHECK_EN];
  wire int_rst = ~pg_s | ~rpin_s | soft_rst;
  wire [23:0] word = chk ? shreg[31:8] : short_word;
  wire [31:0] frame = {word, 8'h00};
  wire len_ok = chk ? (cnt == 6'(FRAME_BITS)) : (cnt == 6'(SHORT_BITS) || cnt == 6'(FRAME_BITS));
  wire crc_ok = ~chk | (dsfr_crc8(shreg[31:8]) == shreg[7:0]);
  wire [1:0] f_dev = frame[DEVA_MSB:DEVA_LSB];
  wire [4:0] f_reg = frame[REGA_MSB:REGA_LSB];
  wire [15:0] f_data = frame[DATA_MSB:DATA_LSB];
  wire good = len_ok & crc_ok;
  wire accept = frame_end & good & (f_dev == addr_s);
  wire dual = f_data[OC_VOLT_EN] & f_data[OC_CURR_EN];
  wire wr_dac = accept & (f_reg == REG_DAC_INPUT);
  wire wr_oc = accept & (f_reg == REG_OUT_CONFIG) & ~dual;
  wire wr_gs = accept & (f_reg == REG_GEN_SETUP_ONE);
  wire wr_cs = accept & (f_reg == REG_CONV_SETUP_TWO);
  wire wr_key = accept & (f_reg == REG_KEY);

  ////////////////////////////////////////////////////////////////
  // shift register
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
      shreg <= 32'h00000000;
      short_word <= 24'h000000;
      cnt <= 6'h00;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_q <= cs_s;
      if (cs_s || int_rst)
      begin
        cnt <= 6'h00;
      end
      else if (sclk_fall)
      begin
        shreg <= {shreg[30:0], sdi_s};
        if (cnt != 6'h3F)
        begin
          cnt <= cnt + 6'h01;
        end
        if (cnt == 6'(SHORT_BITS - 1))
        begin
          short_word <= {shreg[22:0], sdi_s};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      DAC_CODE <= DAC_RST;
      out_cfg <= OUT_CONFIG_RST;
      gen_setup <= GEN_SETUP_RST;
      conv_setup <= CONV_SETUP_RST;
      CAL_REFRESHED <= 1'b0;
      soft_rst <= 1'b0;
      IN_RESET <= 1'b1;
      FRAME_ERR <= 1'b0;
    end
    else if (int_rst)
    begin
      DAC_CODE <= DAC_RST;
      out_cfg <= OUT_CONFIG_RST;
      gen_setup <= GEN_SETUP_RST;
      conv_setup <= CONV_SETUP_RST;
      CAL_REFRESHED <= 1'b0;
      soft_rst <= 1'b0;
      IN_RESET <= 1'b1;
      FRAME_ERR <= 1'b0;
    end
    else
    begin
      IN_RESET <= 1'b0;
      FRAME_ERR <= frame_end & (cnt != 6'h00) & ~good;
      if (wr_dac)
      begin
        DAC_CODE <= f_data;
      end
      if (wr_oc)
      begin
        out_cfg <= f_data;
      end
      if (wr_gs)
      begin
        gen_setup <= f_data;
      end
      if (wr_cs)
      begin
        conv_setup <= f_data;
      end
      soft_rst <= wr_key & (f_data == KEY_SOFT_RESET);
      if (wr_key && f_data == KEY_CAL_REFRESH)
      begin
        CAL_REFRESHED <= 1'b1;
      end
    end
  end

  assign VOLT_EN = out_cfg[OC_VOLT_EN];
  assign CURR_EN = out_cfg[OC_CURR_EN];
  assign VOLT_RANGE = out_cfg[OC_VRANGE_LSB+1:OC_VRANGE_LSB];
  assign OVERRANGE_EN = out_cfg[OC_OVERRANGE];
  assign CURR_RANGE = out_cfg[OC_CRANGE_LSB+2:OC_CRANGE_LSB];
  assign EXT_RESISTOR = out_cfg[OC_EXT_RES];
  assign PULLDOWN_CLOSED = conv_setup[CS_PULLDOWN];
  assign CHECK_EN = chk;
endmodule : dsfr_device

/* tb/dsfr_link_monitor.sv */
`timescale 1ns/100ps
module dsfr_link_monitor
  import dsfr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  input wire logic reset_b
);
  logic sclk_q;
  logic [5:0] falls;
  int quiet;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////
  // falls per frame, cycles since reset pin release
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sclk_q <= 1'b1;
      falls <= 6'h00;
      quiet <= QUIET_CYC;
    end
    else
    begin
      sclk_q <= sclk;
      falls <= cs_b ? 6'h00 : falls + {5'h00, sclk_q & ~sclk};
      quiet <= !reset_b ? 0 : ((quiet < QUIET_CYC) ? quiet + 1 : quiet);
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_low_half;
    (!sclk)[*4] ##1 sclk;
  endsequence
  sequence s_pin_pulse;
    (!reset_b && cs_b)[*8] ##1 reset_b;
  endsequence
  sequence s_lead_in;
    !sdi ##0 sclk[*3] ##[1:2] !sclk;
  endsequence
  property p_fall_framed;
    $fell(sclk) |-> !cs_b && $stable(sdi);
  endproperty
  property p_low_half;
    $fell(sclk) |-> s_low_half;
  endproperty
  property p_high_half;
    $rose(sclk) |-> sclk[*4];
  endproperty
  property p_idle_high;
    cs_b |-> sclk;
  endproperty
  property p_frame_len;
    $rose(cs_b) |-> falls == 6'h20;
  endproperty
  property p_lead_in;
    $fell(cs_b) |-> s_lead_in;
  endproperty
  property p_pin_pulse;
    $fell(reset_b) |-> s_pin_pulse;
  endproperty
  property p_quiet;
    $fell(cs_b) |-> quiet >= QUIET_CYC;
  endproperty
  a_fall_framed: assert property (p_fall_framed) else $error("sdi moved at sclk fall");
  a_low_half: assert property (p_low_half) else $error("sclk low half wrong");
  a_high_half: assert property (p_high_half) else $error("sclk high half short");
  a_idle_high: assert property (p_idle_high) else $error("sclk low outside frame");
  a_frame_len: assert property (p_frame_len) else $error("frame not 32 falls");
  a_lead_in: assert property (p_lead_in) else $error("bad frame start");
  a_pin_pulse: assert property (p_pin_pulse) else $error("reset pulse wrong");
  a_quiet: assert property (p_quiet) else $error("frame too soon after reset");
endmodule : dsfr_link_monitor

/* tb/dac_serial_frame_and_reset_tb_top.sv */
`timescale 1ns/100ps
module dac_serial_frame_and_reset_tb_top;
  import dsfr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic power_good = 1'b1;
  logic [15:0] dac_code, dac_code_b;
  logic volt_en, curr_en, overrange_en, ext_resistor, pulldown_closed, check_en;
  logic cal_refreshed, in_reset, frame_err_b;
  logic [1:0] volt_range;
  logic [2:0] curr_range;
  logic [31:0] s;
  logic [23:0] f;
  logic [15:0] codes [2] = '{16'hFFFF, 16'h8000};
  int errs_b = 0;
  int miscompares = 0;
  int comparisons = 0;
  wire logic [4:0] flags = {volt_en, curr_en, pulldown_closed, check_en, cal_refreshed};
  dsfr_link_if link();
  dsfr_link_if link_b();
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (frame_err_b === 1'b1) errs_b <= errs_b + 1;
  ////////////////////////////////////////////////////////////////
  dsfr_host #(.CAL_WAIT_CYCLES(50)) u_dsfr_host (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  dsfr_device u_dsfr_device (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link), .POWER_GOOD(power_good),
    .DEV_ADDR(2'h2), .DAC_CODE(dac_code), .VOLT_EN(volt_en), .CURR_EN(curr_en), .VOLT_RANGE(volt_range),
    .OVERRANGE_EN(overrange_en), .CURR_RANGE(curr_range), .EXT_RESISTOR(ext_resistor),
    .PULLDOWN_CLOSED(pulldown_closed), .CHECK_EN(check_en), .CAL_REFRESHED(cal_refreshed),
    .IN_RESET(in_reset), .FRAME_ERR());
  // second device driven by the bench for malformed frames
  dsfr_device u_dsfr_device_b (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link_b), .POWER_GOOD(power_good),
    .DEV_ADDR(2'h0), .DAC_CODE(dac_code_b), .VOLT_EN(), .CURR_EN(), .VOLT_RANGE(), .OVERRANGE_EN(),
    .CURR_RANGE(), .EXT_RESISTOR(), .PULLDOWN_CLOSED(), .CHECK_EN(), .CAL_REFRESHED(), .IN_RESET(),
    .FRAME_ERR(frame_err_b));
  dsfr_link_monitor u_dsfr_link_monitor (.CLK_SYS(clk_sys), .RST_B(rst_b), .sclk(link.sclk),
    .cs_b(link.cs_b), .sdi(link.sdi), .reset_b(link.reset_b));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic idle;
    for (int i = 0; i < 3000; i++)
    begin
      rd_reg(HOST_STATUS, s);
      if (s[3] === 1'b0)
        break;
    end
    check("busy", 32'(s[3]), 32'h0);
    repeat (8) @(posedge clk_sys);
  endtask : idle
  task automatic send(input logic [4:0] r, input logic [15:0] d);
    wr_reg(HOST_FRAME, {11'h000, r, d});
    idle();
  endtask : send
  function automatic logic [7:0] crc_of(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
    begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc_of
  // n bits msb first, line inverted once released
  task automatic bang(input logic [31:0] w, input int n);
    @(posedge clk_sys);
    link_b.cs_b <= 1'b0;
    for (int i = 31; i > 31 - n; i--)
    begin
      link_b.sdi <= w[i];
      repeat (4) @(posedge clk_sys);
      link_b.sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      link_b.sclk <= 1'b1;
    end
    repeat (4) @(posedge clk_sys);
    link_b.cs_b <= 1'b1;
    link_b.sdi <= ~w[32 - n];
    repeat (10) @(posedge clk_sys);
  endtask : bang
  ////////////////////////////////////////////////////////////////
  initial
  begin
    link_b.sclk = 1'b1;
    link_b.cs_b = 1'b1;
    link_b.sdi = 1'b0;
    link_b.reset_b = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 check("in_reset", 32'(in_reset), 32'h0);
    check("flags", 32'(flags), 32'h02);
    rd_reg(4'hC, s);
    check("unmapped", s, 32'h0);
    f = {1'b0, 2'h0, REG_DAC_INPUT, 16'h5A3C};
    bang({f, crc_of(f) ^ 8'h01}, 32);
    check("dac_b", 32'(dac_code_b), 32'h0);
    bang({f, crc_of(f)}, 31);
    check("errs_b", 32'(errs_b), 32'h2);
    bang({f, crc_of(f)}, 32);
    check("dac_b", 32'(dac_code_b), 32'h5A3C);
    f = {1'b0, 2'h0, REG_GEN_SETUP_ONE, 16'h0000};
    bang({f, crc_of(f)}, 32);
    bang({1'b0, 2'h0, REG_DAC_INPUT, 16'hC3A5, 8'h00}, 24);
    check("dac_b", 32'(dac_code_b), 32'hC3A5);
    bang({1'b0, 2'h0, REG_DAC_INPUT, 16'h0F0F, 8'hFF}, 32);
    check("dac_b", 32'(dac_code_b), 32'h0F0F);
    wr_reg(HOST_CTRL, 32'h4);
    send(REG_OUT_CONFIG, 16'h001D);
    check("refused", 32'({s[0], flags}), 32'h22);
    wr_reg(HOST_FRAME, {11'h000, REG_KEY, KEY_CAL_REFRESH});
    // frame done near 261 cycles, host must hold off 50 more
    repeat (280) @(posedge clk_sys);
    rd_reg(HOST_STATUS, s);
    check("cal_wait", 32'(s[3]), 32'h1);
    idle();
    check("refresh", 32'({s[1], flags}), 32'h23);
    foreach (codes[i])
    begin
      send(REG_DAC_INPUT, codes[i]);
      check("dac", 32'(dac_code), 32'(codes[i]));
    end
    send(REG_OUT_CONFIG, 16'h001D);
    check("vcfg", 32'({flags, volt_range, overrange_en}), 32'h9F);
    send(REG_OUT_CONFIG, 16'h01A2);
    check("icfg", 32'({flags, curr_range, ext_resistor}), 32'hBB);
    send(REG_OUT_CONFIG, 16'h0003);
    check("flags", 32'(flags), 32'h0B);
    send(REG_CONV_SETUP_TWO, 16'h0001);
    check("flags", 32'(flags), 32'h0F);
    wr_reg(HOST_CTRL, 32'h2);
    send(REG_DAC_INPUT, 16'h1234);
    check("dac", 32'(dac_code), 32'h8000);
    wr_reg(HOST_CTRL, 32'h5);
    repeat (6) @(posedge clk_sys);
    #1 check("in_reset", 32'(in_reset), 32'h1);
    idle();
    check("flags", 32'({dac_code, flags}), 32'h02);
    send(REG_GEN_SETUP_ONE, 16'h0000);
    check("check", 32'({s[2], flags}), 32'h00);
    send(REG_DAC_INPUT, 16'h4321);
    check("dac", 32'(dac_code), 32'h4321);
    send(REG_KEY, KEY_SOFT_RESET);
    check("soft", 32'({dac_code, flags}), 32'h02);
    @(posedge clk_sys);
    power_good <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 check("in_reset", 32'(in_reset), 32'h1);
    @(posedge clk_sys);
    power_good <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check("pg", 32'({in_reset, dac_code_b}), 32'h0);
    test_done();
  end
  initial
  begin
    #3_000_000;
    miscompares++;
    test_done();
  end
endmodule : dac_serial_frame_and_reset_tb_top
